//--- hw/dll_phase_tuning_control.sv
// tap arithmetic, lock tracking and step handshakes of the delay-locked loop
`timescale 1ns/1ps
module dll_phase_tuning_control
  import dll_tune_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  input  wire loop_mode_type mode_in,
  input  wire logic          sleep_n_in,
  input  wire logic          pd_up_in,
  input  wire logic          pd_dn_in,
  input  wire logic          code_refresh_in,
  input  wire logic          code_step_in,
  input  wire logic          phase_step_in,
  input  wire step_ctrl_type step_ctrl_in,
  input  wire logic [7:0]    code_preset_in,
  input  wire clk_cfg_type   clk_cfg_in,
  output logic [7:0]         tap_code_out,
  output logic               code_stale_flag_out,
  output logic               lock_out,
  output logic               code_step_ack_out,
  output logic               phase_step_ack_out,
  output logic               detector_sel_out,
  output clk_ctrl_type       clk_ctrl_out
);
  // ============================================================
  // tap arithmetic unit
  function automatic logic [7:0] tap_move(input logic [7:0] v, input logic dir);
    logic [7:0] r;
    r = v;
    if (dir && v != TAP_TOP) begin
      r = v + 8'h01;
    end else if (!dir && v != TAP_BOTTOM) begin
      r = v - 8'h01;
    end
    return r;
  endfunction

  localparam logic [1:0] REFRESH_LAST = 2'(REFRESH_MIN_CYCLES - 1);
  localparam logic [3:0] SETTLE_LAST  = 4'(LOCK_SETTLE_CYCLES - 1);

  // ============================================================
  // phase detector synchroniser
  logic [1:0] pd_meta_r;
  logic [1:0] pd_sync_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_meta_r <= 2'h0;
      pd_sync_r <= 2'h0;
    end else begin
      pd_meta_r <= {pd_up_in, pd_dn_in};
      pd_sync_r <= pd_meta_r;
    end
  end
  wire pd_up   = pd_sync_r[1];
  wire pd_dn   = pd_sync_r[0];
  wire aligned = !pd_up && !pd_dn;

  // ============================================================
  // edge detection of the fabric strobes
  logic code_step_d_r;
  logic phase_step_d_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_step_d_r  <= 1'b0;
      phase_step_d_r <= 1'b0;
    end else begin
      code_step_d_r  <= code_step_in;
      phase_step_d_r <= phase_step_in;
    end
  end
  wire code_rise  = sleep_n_in && code_step_in && !code_step_d_r;
  wire code_fall  = !code_step_in && code_step_d_r;
  wire phase_rise = sleep_n_in && phase_step_in && !phase_step_d_r;
  wire phase_fall = !phase_step_in && phase_step_d_r;

  // ============================================================
  // internal calculation follows the detector
  logic [7:0] calc_r;
  logic [7:0] calc_nxt;
  assign calc_nxt = !sleep_n_in ? calc_r :
                    pd_up       ? tap_move(calc_r, 1'b1) :
                    pd_dn       ? tap_move(calc_r, 1'b0) : calc_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      calc_r <= TAP_RESET;
    end else begin
      calc_r <= calc_nxt;
    end
  end

  // ============================================================
  // refresh request qualification
  logic [1:0] refresh_cnt_r;
  logic [1:0] refresh_cnt_nxt;
  assign refresh_cnt_nxt = !(code_refresh_in && sleep_n_in) ? 2'h0 :
                           (refresh_cnt_r == REFRESH_LAST) ? refresh_cnt_r :
                           refresh_cnt_r + 2'h1;
  wire refresh_go = sleep_n_in && code_refresh_in && refresh_cnt_r == REFRESH_LAST;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_cnt_r <= 2'h0;
    end else begin
      refresh_cnt_r <= refresh_cnt_nxt;
    end
  end

  // ============================================================
  // output tap code: step wins over refresh
  logic [7:0] code_r;
  logic [7:0] code_nxt;
  logic       stale_r;
  assign code_nxt = !code_rise             ? (refresh_go ? calc_r : code_r) :
                    step_ctrl_in.reload    ? code_preset_in :
                    tap_move(code_r, step_ctrl_in.dir);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_r  <= TAP_RESET;
      stale_r <= 1'b0;
    end else begin
      code_r  <= code_nxt;
      stale_r <= sleep_n_in && (code_nxt != calc_nxt);
    end
  end
  assign tap_code_out        = code_r;
  assign code_stale_flag_out = stale_r;

  // ============================================================
  // step handshakes
  step_state_type code_st_r;
  step_state_type code_st_nxt;
  step_state_type phase_st_r;
  step_state_type phase_st_nxt;
  always_comb begin
    code_st_nxt = code_st_r;
    case (code_st_r)
      STEP_IDLE: begin
        if (code_rise) code_st_nxt = STEP_DONE;
      end
      STEP_DONE: begin
        if (code_fall || !sleep_n_in) code_st_nxt = STEP_IDLE;
      end
      default: code_st_nxt = STEP_IDLE;
    endcase
  end
  always_comb begin
    phase_st_nxt = phase_st_r;
    case (phase_st_r)
      STEP_IDLE: begin
        if (phase_rise) phase_st_nxt = STEP_DONE;
      end
      STEP_DONE: begin
        if (phase_fall || !sleep_n_in) phase_st_nxt = STEP_IDLE;
      end
      default: phase_st_nxt = STEP_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_st_r  <= STEP_IDLE;
      phase_st_r <= STEP_IDLE;
    end else begin
      code_st_r  <= code_st_nxt;
      phase_st_r <= phase_st_nxt;
    end
  end
  assign code_step_ack_out  = code_st_r == STEP_DONE;
  assign phase_step_ack_out = phase_st_r == STEP_DONE;

  // ============================================================
  // secondary clock fine phase, wraps over 32 settings
  logic [4:0] fine_r;
  logic [4:0] fine_nxt;
  assign fine_nxt = !sleep_n_in          ? clk_cfg_in.fine_preset :
                    !phase_rise          ? fine_r :
                    step_ctrl_in.reload  ? clk_cfg_in.fine_preset :
                    step_ctrl_in.dir     ? fine_r + 5'h01 : fine_r - 5'h01;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fine_r <= FINE_RESET;
    end else begin
      fine_r <= fine_nxt;
    end
  end

  // ============================================================
  // delay line settings for both clocks
  wire [2:0]  coarse_sel = (clk_cfg_in.coarse > COARSE_TOP) ? COARSE_TOP : clk_cfg_in.coarse;
  wire [10:0] clk0_mul   = 11'(calc_r) * 11'(coarse_sel);
  wire [12:0] clk1_mul   = 13'(calc_r) * 13'(fine_r);
  wire        gen_mode   = mode_in != MODE_PHASE_REF;
  wire        fine_coarse = fine_r[2:0] == 3'h0;
  clk_ctrl_type ctrl_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r           <= '0;
      detector_sel_out <= 1'b0;
    end else begin
      ctrl_r.clk0_taps <= gen_mode ? clk0_mul : 11'h000;
      ctrl_r.clk1_taps <= gen_mode ? {1'b0, clk1_mul[12:FINE_SHIFT]} : 11'h000;
      ctrl_r.fine      <= fine_r;
      ctrl_r.div_sel   <= (clk_cfg_in.div_sel == DIV_BY2 || clk_cfg_in.div_sel == DIV_BY4) ?
                          clk_cfg_in.div_sel : DIV_NONE;
      ctrl_r.duty0_en  <= clk_cfg_in.duty0_en;
      ctrl_r.duty1_en  <= clk_cfg_in.duty1_en && fine_coarse;
      detector_sel_out <= mode_in == MODE_INJ_REMOVE;
    end
  end
  assign clk_ctrl_out = ctrl_r;

  // ============================================================
  // lock tracking
  lock_state_type lock_st_r;
  lock_state_type lock_st_nxt;
  logic [3:0]     settle_r;
  logic [3:0]     settle_nxt;
  always_comb begin
    lock_st_nxt = lock_st_r;
    settle_nxt  = 4'h0;
    case (lock_st_r)
      LOCK_OFF: begin
        if (sleep_n_in) lock_st_nxt = LOCK_SEEK;
      end
      LOCK_SEEK: begin
        if (!sleep_n_in) begin
          lock_st_nxt = LOCK_OFF;
        end else if (aligned && settle_r == SETTLE_LAST) begin
          lock_st_nxt = LOCK_HELD;
        end else if (aligned) begin
          settle_nxt = settle_r + 4'h1;
        end
      end
      LOCK_HELD: begin
        if (!sleep_n_in) lock_st_nxt = LOCK_OFF;
      end
      default: lock_st_nxt = LOCK_OFF;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_st_r <= LOCK_OFF;
      settle_r  <= 4'h0;
    end else begin
      lock_st_r <= lock_st_nxt;
      settle_r  <= settle_nxt;
    end
  end
  assign lock_out = lock_st_r == LOCK_HELD;

  // ============================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  refresh_update_a: assert property (
    sleep_n_in && code_refresh_in && $past(code_refresh_in) && $past(sleep_n_in) && !code_rise
    |=> code_r == $past(calc_r))
    else $error("refresh did not load the calculated code");
  code_add_a: assert property (
    code_rise && !step_ctrl_in.reload && step_ctrl_in.dir && code_r != TAP_TOP
    |=> code_r == $past(code_r) + 8'h01)
    else $error("code step up did not add one tap");
  code_reload_a: assert property (
    code_rise && step_ctrl_in.reload |=> code_r == $past(code_preset_in))
    else $error("code reload did not restore preset");
  code_ack_a: assert property (
    code_rise && code_st_r == STEP_IDLE |=>
      code_step_ack_out ##1 (code_step_ack_out || !code_step_in || !$past(sleep_n_in)))
    else $error("code step acknowledge missing");
  code_ack_clear_a: assert property (
    code_step_ack_out && code_fall |=> !code_step_ack_out)
    else $error("code acknowledge not cleared on strobe fall");
  phase_sub_a: assert property (
    phase_rise && !step_ctrl_in.reload && !step_ctrl_in.dir |=> fine_r == $past(fine_r) - 5'h01)
    else $error("phase step down did not subtract one tap");
  phase_ack_a: assert property (
    phase_rise |=> phase_step_ack_out until_with (!phase_step_in || !sleep_n_in))
    else $error("phase acknowledge dropped before strobe fall");
  phase_ack_clear_a: assert property (
    phase_step_ack_out && phase_fall |=> !phase_step_ack_out)
    else $error("phase acknowledge not cleared on strobe fall");
  stale_flag_a: assert property (
    sleep_n_in && $past(sleep_n_in) |-> code_stale_flag_out == (code_r != calc_r))
    else $error("stale flag disagrees with code and calculation");
  sleep_quiet_a: assert property (
    !sleep_n_in |=> !lock_out && !code_step_ack_out && !phase_step_ack_out && $stable(code_r))
    else $error("activity while asleep");
  lock_settle_a: assert property (
    $rose(lock_out) |-> $past(aligned) && $past(settle_r) == SETTLE_LAST)
    else $error("lock without settled alignment");
  fine_glitch_a: assert property (
    sleep_n_in && !(phase_rise && step_ctrl_in.reload) && $changed(fine_nxt) |->
      (fine_nxt == fine_r + 5'h01) || (fine_nxt == fine_r - 5'h01))
    else $error("secondary phase jumped more than one tap");
  coarse_range_a: assert property (
    ##1 $past(gen_mode) |-> clk_ctrl_out.clk0_taps == 11'($past(calc_r)) * 11'($past(coarse_sel)))
    else $error("primary delay not a quarter multiple");

  lock_reach_c: cover property (sleep_n_in ##1 lock_out);
  code_step_c: cover property (code_rise ##1 code_step_ack_out ##[1:20] !code_step_ack_out);
  phase_reload_c: cover property (phase_rise && step_ctrl_in.reload);
  refresh_hold_c: cover property (refresh_go [*4]);
endmodule

//--- hw/dll_tune_pkg.sv
// constants and types for the delay-loop tuning control
package dll_tune_pkg;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int REFRESH_MIN_CYCLES = 2;
  localparam int LOCK_SETTLE_NS     = 800;
  localparam int LOCK_SETTLE_CYCLES = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ============================================================
  // widths and values
  localparam int         TAP_W       = 8;
  localparam int         FINE_W      = 5;
  localparam int         DELAY_W     = 11;
  localparam logic [7:0] TAP_RESET   = 8'h40;
  localparam logic [7:0] TAP_TOP     = 8'hFF;
  localparam logic [7:0] TAP_BOTTOM  = 8'h00;
  localparam logic [2:0] COARSE_TOP  = 3'h4;
  localparam logic [4:0] FINE_RESET  = 5'h00;
  localparam logic [1:0] DIV_NONE    = 2'h0;
  localparam logic [1:0] DIV_BY2     = 2'h1;
  localparam logic [1:0] DIV_BY4     = 2'h2;
  localparam int         FINE_SHIFT  = 3;
  // ============================================================
  // types
  typedef enum logic [1:0] {
    MODE_PHASE_REF  = 2'b00,
    MODE_PHASE_GEN  = 2'b01,
    MODE_INJ_REMOVE = 2'b10
  } loop_mode_type;
  typedef enum logic [1:0] {
    LOCK_OFF  = 2'b00,
    LOCK_SEEK = 2'b01,
    LOCK_HELD = 2'b10
  } lock_state_type;
  typedef enum logic {
    STEP_IDLE = 1'b0,
    STEP_DONE = 1'b1
  } step_state_type;
  typedef struct packed {
    logic dir;
    logic reload;
  } step_ctrl_type;
  typedef struct packed {
    logic [2:0] coarse;
    logic [4:0] fine_preset;
    logic [1:0] div_sel;
    logic       duty0_en;
    logic       duty1_en;
  } clk_cfg_type;
  typedef struct packed {
    logic [10:0] clk0_taps;
    logic [10:0] clk1_taps;
    logic [4:0]  fine;
    logic [1:0]  div_sel;
    logic        duty0_en;
    logic        duty1_en;
  } clk_ctrl_type;
endpackage

//--- tb/fabric_model.sv
// fabric-side model of the single-tap step handshake
`timescale 1ns/1ps
module fabric_model
  import dll_tune_pkg::*;
(
  input  wire logic    core_clk_in,
  input  wire logic    code_ack_in,
  input  wire logic    phase_ack_in,
  output logic         code_step_out,
  output logic         phase_step_out,
  output step_ctrl_type step_ctrl_out
);
  initial begin
    code_step_out  = 1'b0;
    phase_step_out = 1'b0;
    step_ctrl_out  = '0;
  end
  // ============================================================
  // one strobe cycle; acked reports whether the done flag rose
  task automatic step(input logic ph, input logic dir, input logic reload, output logic acked);
    int n;
    n = 0;
    acked = 1'b0;
    @(negedge core_clk_in);
    step_ctrl_out = '{dir: dir, reload: reload};
    if (ph) phase_step_out = 1'b1;
    else code_step_out = 1'b1;
    while (n < 20 && !acked) begin
      @(negedge core_clk_in);
      acked = ph ? phase_ack_in : code_ack_in;
      n++;
    end
    code_step_out  = 1'b0;
    phase_step_out = 1'b0;
    n = 0;
    while (n < 6 && (ph ? phase_ack_in : code_ack_in) !== 1'b0) begin
      @(negedge core_clk_in);
      n++;
    end
    step_ctrl_out = ~step_ctrl_out;
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the delay-loop tuning control
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module tb_top
  import dll_tune_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  loop_mode_type mode = MODE_PHASE_REF;
  logic          sleep_n = 1'b1;
  logic          pd_up = 1'b0;
  logic          pd_dn = 1'b0;
  logic          refresh = 1'b0;
  logic [7:0]    preset = 8'h00;
  clk_cfg_type   cfg = '0;
  logic          code_step, phase_step, code_ack, phase_ack, stale, lock, ack, dir, det_sel;
  step_ctrl_type step_ctrl;
  logic [7:0]    tap_code;
  clk_ctrl_type  clk_ctrl;
  logic [7:0]    presets [$];
  int            bad_count = 0;
  int            num_checks = 0;
  int            seed = 52;
  int            m_calc, m_code, m_fine, i, k;

  always #50 clk = ~clk;

  dll_phase_tuning_control DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .mode_in(mode), .sleep_n_in(sleep_n),
    .pd_up_in(pd_up), .pd_dn_in(pd_dn), .code_refresh_in(refresh), .code_step_in(code_step),
    .phase_step_in(phase_step), .step_ctrl_in(step_ctrl), .code_preset_in(preset),
    .clk_cfg_in(cfg), .tap_code_out(tap_code), .code_stale_flag_out(stale), .lock_out(lock),
    .code_step_ack_out(code_ack), .phase_step_ack_out(phase_ack), .detector_sel_out(det_sel),
    .clk_ctrl_out(clk_ctrl));

  fabric_model fab (
    .core_clk_in(clk), .code_ack_in(code_ack), .phase_ack_in(phase_ack),
    .code_step_out(code_step), .phase_step_out(phase_step), .step_ctrl_out(step_ctrl));

  // ============================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_pd(input logic up, input int n);
    if (up) pd_up = 1'b1;
    else pd_dn = 1'b1;
    cyc(n);
    pd_up = 1'b0;
    pd_dn = 1'b0;
  endtask
  task automatic endt(input string name);
    $display("test %s done", name);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ============================================================
  // main sequence
  initial begin
    presets.push_back(8'($random(seed)));
    presets.push_back(8'h00);
    presets.push_back(8'hFF);
    cyc(19);
    `CHK(tap_code, TAP_RESET)
    `CHK({lock, code_ack, phase_ack}, 3'b000)
    cyc(1);
    rst_n = 1'b1;
    cyc(12);
    `CHK(lock, 1'b1)
    `CHK(det_sel, 1'b0)
    `CHK(clk_ctrl.clk0_taps, 11'h000)
    m_calc = 64;
    m_code = 64;
    endt("lock");
    pulse_pd(1'b1, 5);
    m_calc += 5;
    cyc(4);
    `CHK(stale, 1'b1)
    refresh = 1'b1;
    cyc(1);
    refresh = 1'b0;
    cyc(3);
    `CHK(tap_code, 8'(m_code))
    refresh = 1'b1;
    cyc(4);
    m_code = m_calc;
    `CHK(tap_code, 8'(m_code))
    `CHK(stale, 1'b0)
    pulse_pd(1'b0, 3);
    m_calc -= 3;
    cyc(6);
    m_code = m_calc;
    `CHK(tap_code, 8'(m_code))
    refresh = 1'b0;
    endt("refresh");
    for (k = 0; k < 3; k++) begin
      preset = presets[k];
      for (i = 0; i < 5; i++) begin
        dir = (k == 0) ? 1'($random(seed)) : (k == 2);
        fab.step(1'b0, dir, i == 0, ack);
        `CHK(ack, 1'b1)
        `CHK(code_ack, 1'b0)
        m_code = (i == 0) ? preset : dir ? (m_code == 255 ? 255 : m_code + 1) : (m_code == 0 ? 0 : m_code - 1);
        `CHK(tap_code, 8'(m_code))
      end
    end
    endt("code step");
    mode = MODE_PHASE_GEN;
    cfg.coarse = 3'h2;
    cfg.fine_preset = 5'($random(seed));
    for (i = 0; i < 7; i++) begin
      dir = 1'($random(seed));
      fab.step(1'b1, dir, i == 0, ack);
      `CHK(ack, 1'b1)
      `CHK(phase_ack, 1'b0)
      m_fine = (i == 0) ? int'(cfg.fine_preset) : (m_fine + (dir ? 1 : 31)) % 32;
      `CHK(clk_ctrl.fine, 5'(m_fine))
      `CHK(clk_ctrl.clk1_taps, 11'(m_calc * m_fine / 8))
    end
    `CHK(clk_ctrl.clk0_taps, 11'(m_calc * 2))
    for (i = 0; i < 4; i++) begin
      cfg.div_sel = 2'(i);
      cyc(2);
      `CHK(clk_ctrl.div_sel, 2'((i == 1 || i == 2) ? i : 0))
    end
    cfg.duty0_en = 1'b1;
    cfg.duty1_en = 1'b1;
    cfg.fine_preset = 5'h08;
    fab.step(1'b1, 1'b0, 1'b1, ack);
    m_fine = 8;
    `CHK(clk_ctrl.duty0_en, 1'b1)
    `CHK(clk_ctrl.duty1_en, 1'b1)
    fab.step(1'b1, 1'b1, 1'b0, ack);
    m_fine = 9;
    `CHK(clk_ctrl.duty1_en, 1'b0)
    mode = MODE_INJ_REMOVE;
    cfg.coarse = 3'h7;
    cyc(2);
    `CHK(det_sel, 1'b1)
    `CHK(clk_ctrl.clk0_taps, 11'(m_calc * 4))
    `CHK(clk_ctrl.clk1_taps, 11'(m_calc * m_fine / 8))
    endt("phase gen");
    sleep_n = 1'b0;
    cyc(2);
    `CHK(lock, 1'b0)
    fab.step(1'b0, 1'b1, 1'b0, ack);
    `CHK(ack, 1'b0)
    `CHK(tap_code, 8'(m_code))
    sleep_n = 1'b1;
    cyc(12);
    `CHK(lock, 1'b1)
    endt("sleep");
    summarize();
  end
endmodule
